/* File: design/atwr_regs.svh */
// Purpose: Constants for the three-wire accelerometer reader
// Assumes: 20 MHz system clock
// Notes:   Sensor register map and format values
`ifndef ATWR_REGS_SVH
`define ATWR_REGS_SVH
`define ATWR_EVENT_SOURCE_FLAGS     6'h30
`define ATWR_OUTPUT_FORMAT_CONTROL  6'h31
`define ATWR_AXIS_FIRST             6'h32
`define ATWR_RATE_CONTROL           6'h2c
`define ATWR_FORMAT_VALUE           8'h40
`define ATWR_RATE_VALUE             8'h0c
`define ATWR_READY_BIT              7
`define ATWR_CLK_HZ                 20000000
`define ATWR_SCLK_HZ                2000000
`define ATWR_HALF_CYC               ((`ATWR_CLK_HZ / `ATWR_SCLK_HZ) / 2)
`define ATWR_AXIS_BYTES             6
`endif

/* File: design/atwr_pkg.sv */
// Purpose: Types for the three-wire accelerometer reader
// Assumes: Nothing
// Notes:   States of the sequencer
`default_nettype none
package atwr_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_FMT, ST_RATE, ST_POLL, ST_CHECK, ST_READ, ST_PUSH} atwr_state_t;
	typedef logic [7:0] atwr_byte_t;
endpackage
`default_nettype wire

/* File: design/atwr_fifo.sv */
// Purpose: Sample FIFO whose flags pace the link reader and the consumer; the reader leaves its data output open
// Assumes: Single clock
// Notes:   Valid/ready on both sides, full and empty honest
`default_nettype none
module atwr_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	assign out_data_o  = mem_r[rd_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Next fill count, shared by the count and both registered flags
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
	end

	// Storage, no reset needed
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_r[wr_r] <= in_data_i;
	end

	// Pointers and fill count
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wr_r        <= '0;
			rd_r        <= '0;
			cnt_r       <= '0;
			in_ready_o  <= 1'b1;
			out_valid_o <= 1'b0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			cnt_r       <= cnt_nxt;
			// Flags from flops so the two flag outputs carry no decode glitches
			in_ready_o  <= (cnt_nxt != (AW+1)'(DEPTH));
			out_valid_o <= (cnt_nxt != '0);
		end
	end
endmodule // atwr_fifo
`default_nettype wire

/* File: design/atwr_reader.sv */
// Purpose: Configure a three-axis sensor and stream its samples over three-wire SPI
// Assumes: clk_i at 20 MHz; sensor keeps its register layout and sample format
// Notes:   Link clock is derived here, so it is no second domain
`include "atwr_regs.svh"
`default_nettype none
module atwr_reader (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    resetn_i,
	// Control
	input  wire logic                    enable_i,
	// Sample stream
	output logic                         smp_valid_o,
	input  wire logic                    smp_ready_i,
	output logic                  [47:0] smp_data_o,
	output logic                   [7:0] event_flags_o,
	// Three-wire link
	output logic                         spi_sclk_o,
	output logic                         spi_csn_o,
	output logic                         spi_sdio_o,
	output logic                         spi_sdio_oen_o,
	input  wire logic                    spi_sdio_i
);
	import atwr_pkg::*;

	// Link rate derived from the system clock, no second clock domain
	localparam logic [3:0] HALF = 4'(`ATWR_HALF_CYC);

	atwr_state_t state_r;
	logic [3:0]  div_r;
	logic        xfer_r;
	logic [5:0]  bit_r;
	logic [5:0]  nbits_r;
	logic        rd_r;
	logic [15:0] tx_r;
	logic [47:0] rx_r;
	logic        sdio_m_r;
	logic        sdio_s_r;
	logic        fifo_ready;
	logic        push_r;
	logic        tick;
	logic        done;
	atwr_byte_t  ev_byte;

	// Build command byte: read flag, multi-byte flag, address
	function automatic logic [7:0] cmd(input logic rd, input logic mb, input logic [5:0] a);
		return {rd, mb, a};
	endfunction

	assign tick = xfer_r && (div_r == HALF - 4'h1);
	assign done = tick && !spi_sclk_o && (bit_r == nbits_r - 6'h1);
	// Event byte as it completes on the last rising edge of a poll
	assign ev_byte = {rx_r[6:0], sdio_s_r};

	// Input data pin synchroniser
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sdio_m_r <= 1'b0;
			sdio_s_r <= 1'b0;
		end
		else
		begin
			sdio_m_r <= spi_sdio_i;
			sdio_s_r <= sdio_m_r;
		end
	end

	// Half-period divider for the serial clock
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			div_r <= 4'h0;
		else if (!xfer_r || tick)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end

	// Serial engine: clock idles high, falling edge launches, rising samples
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			spi_sclk_o     <= 1'b1;
			spi_csn_o      <= 1'b1;
			spi_sdio_o     <= 1'b1;
			spi_sdio_oen_o <= 1'b1;
			bit_r          <= 6'h0;
			rx_r           <= 48'h0;
		end
		else if (!xfer_r)
		begin
			spi_sclk_o     <= 1'b1;
			spi_csn_o      <= 1'b1;
			spi_sdio_oen_o <= 1'b1;
			bit_r          <= 6'h0;
		end
		else if (!tick)
			spi_csn_o <= 1'b0; // Select leads the first falling edge by a few cycles
		else
		begin
			if (spi_sclk_o)
			begin
				// Falling edge: launch while in command or write bits
				spi_sclk_o <= 1'b0;
				if (!rd_r || bit_r < 6'h8)
				begin
					spi_sdio_o     <= tx_r[15 - bit_r[3:0]];
					spi_sdio_oen_o <= 1'b0;
				end
				else
					spi_sdio_oen_o <= 1'b1;
			end
			else
			begin
				// Rising edge: sensor samples, we capture read bits
				spi_sclk_o <= 1'b1;
				if (rd_r && bit_r >= 6'h8)
					rx_r <= {rx_r[46:0], sdio_s_r};
				bit_r <= bit_r + 6'h1;
			end
		end
	end

	// Sequencer: format, rate, then poll and burst until enable_i is low at the end of a burst
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_r       <= ST_IDLE;
			xfer_r        <= 1'b0;
			rd_r          <= 1'b0;
			nbits_r       <= 6'h10;
			tx_r          <= 16'h0;
			push_r        <= 1'b0;
			smp_data_o    <= 48'h0;
			event_flags_o <= 8'h0;
		end
		else
		begin
			push_r <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					if (enable_i && !xfer_r)
					begin
						tx_r    <= {cmd(1'b0, 1'b0, `ATWR_OUTPUT_FORMAT_CONTROL), `ATWR_FORMAT_VALUE};
						rd_r    <= 1'b0;
						nbits_r <= 6'h10;
						xfer_r  <= 1'b1;
						state_r <= ST_FMT;
					end
				end
				ST_FMT:
				begin
					if (done)
					begin
						tx_r    <= {cmd(1'b0, 1'b0, `ATWR_RATE_CONTROL), `ATWR_RATE_VALUE};
						xfer_r  <= 1'b0; // Each write needs its own select frame
						state_r <= ST_RATE;
					end
				end
				ST_RATE:
				begin
					if (!xfer_r)
						xfer_r <= 1'b1;
					else if (done)
					begin
						xfer_r  <= 1'b0;
						state_r <= ST_POLL;
					end
				end
				ST_POLL:
				begin
					if (!xfer_r)
					begin
						tx_r    <= {cmd(1'b1, 1'b0, `ATWR_EVENT_SOURCE_FLAGS), 8'h00};
						rd_r    <= 1'b1;
						nbits_r <= 6'h10;
						xfer_r  <= 1'b1;
						state_r <= ST_CHECK;
					end
				end
				ST_CHECK:
				begin
					if (done)
					begin
						xfer_r        <= 1'b0;
						event_flags_o <= ev_byte;
						if (ev_byte[`ATWR_READY_BIT])
							state_r <= ST_READ;
						else
							state_r <= ST_POLL;
					end
				end
				ST_READ:
				begin
					if (!xfer_r && fifo_ready)
					begin
						tx_r    <= {cmd(1'b1, 1'b1, `ATWR_AXIS_FIRST), 8'h00};
						nbits_r <= 6'(8 + 8 * `ATWR_AXIS_BYTES);
						xfer_r  <= 1'b1;
						state_r <= ST_PUSH;
					end
				end
				ST_PUSH:
				begin
					if (done)
					begin
						// Bytes arrive X low, X high, ... Z high; keep arrival order
						smp_data_o <= {rx_r[46:0], sdio_s_r};
						push_r     <= 1'b1;
						xfer_r     <= 1'b0;
						state_r    <= enable_i ? ST_POLL : ST_IDLE;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	atwr_fifo #(
		.WIDTH (48),
		.DEPTH (32)
	) u_fifo (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (push_r),
		.in_ready_o  (fifo_ready),
		.in_data_i   (smp_data_o),
		.out_valid_o (smp_valid_o),
		.out_ready_i (smp_ready_i),
		.out_data_o  ()
	);

	// Assertions
	AST_IDLE_HIGH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		spi_csn_o |-> spi_sclk_o) else $error("clock low while deselected");
	AST_READ_RELEASE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rd_r && bit_r >= 6'h9 && !spi_csn_o) |-> spi_sdio_oen_o) else $error("data line driven in read phase");
	AST_POLL_FIRST: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(state_r == ST_CHECK && $past(state_r) == ST_POLL) |-> tx_r[15:8] == 8'hb0) else $error("poll address");
	AST_BURST_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state_r == ST_PUSH |-> nbits_r == 6'd56) else $error("burst length");
	AST_FMT_WORD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state_r == ST_FMT |-> tx_r == 16'h3140) else $error("format word");
	AST_RATE_WORD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state_r == ST_RATE |-> tx_r == 16'h2c0c) else $error("rate word");
	AST_HALF: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$fell(spi_sclk_o) |=> !spi_sclk_o [*4]) else $error("short low phase");
	AST_PUSH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		push_r |-> $past(state_r) == ST_PUSH) else $error("stray push");
	AST_SELECT_LEAD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$fell(spi_sclk_o) |-> !$past(spi_csn_o)) else $error("clock fell without select");
	CV_POLL: cover property (@(posedge clk_i) state_r == ST_CHECK ##1 state_r == ST_POLL);
	CV_BURST: cover property (@(posedge clk_i) push_r);
	CV_FULL: cover property (@(posedge clk_i) !fifo_ready);
endmodule // atwr_reader
`default_nettype wire

/* File: testbench/atwr_sensor_model.sv */
// Purpose: Behavioural three-wire sensor for the reader bench
// Assumes: Mode 3 link; command byte is read, multi-byte, 6-bit address
// Notes:   A released line shows the inverse of its last bit, never a held value
`default_nettype none
module atwr_sensor_model (
	input  wire logic sclk_i,
	input  wire logic csn_i,
	input  wire logic sdio_i,
	output logic      sdio_o,
	output logic      drive_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [0:63];
	logic [7:0] cmd;
	logic [7:0] sh;
	int         cnt;
	int         bursts;
	int         early_reads;
	// Known axis bytes, low byte at the lower address
	initial
	begin
		foreach (regs[i]) regs[i] = 8'h00;
		for (int i = 0; i < 6; i++) regs[6'h32 + i] = 8'(8'h11 * (i + 1));
		{sdio_o, drive_o} = 2'b00;
		{cnt, bursts, early_reads} = '0;
	end
	// Capture on rising edges only; event byte cannot be written
	always @(posedge sclk_i)
	begin
		if (!csn_i)
		begin
			if (cnt < 8) cmd = {cmd[6:0], sdio_i};
			else if (!cmd[7]) sh = {sh[6:0], sdio_i};
			cnt = cnt + 1;
			if (cnt == 8 && cmd[7] && regs[6'h31][6] !== 1'b1) early_reads++;
			if (cnt == 8 && cmd == 8'hf2) bursts++;
			if (cnt == 16 && !cmd[7] && cmd[5:0] != 6'h30) regs[cmd[5:0]] = sh;
		end
	end
	// Launch read bits on falling edges, MSB first
	always @(negedge sclk_i)
	begin
		if (!csn_i && cnt >= 8 && cmd[7])
		begin
			drive_o = 1'b1;
			sdio_o = regs[cmd[5:0] + 6'((cnt - 8) / 8)][7 - (cnt - 8) % 8];
		end
	end
	// Select restarts the bit count; deselect lets go of the line
	always @(negedge csn_i) cnt = 0;
	always @(posedge csn_i)
	begin
		drive_o = 1'b0;
		sdio_o = ~sdio_o;
	end
endmodule // atwr_sensor_model
`default_nettype wire

/* File: testbench/tb_atwr_reader.sv */
// Purpose: Self-checking bench for the three-wire accelerometer reader
// Assumes: Sensor model on the link, 20 MHz clock
// Notes:   Fill test holds the consumer off for 32 bursts, so the run is long
`default_nettype none
module tb_atwr_reader;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, resetn_i, enable_i, smp_ready_i;
	logic        smp_valid_o, spi_sclk_o, spi_csn_o, spi_sdio_o, spi_sdio_oen_o, m_sdio, m_drive;
	logic [47:0] smp_data_o;
	logic [7:0]  event_flags_o;
	wire         sdio = !spi_sdio_oen_o ? spi_sdio_o : m_sdio;
	int          errors, num_checks, faults;
	atwr_reader atwr_reader_i (.clk_i(clk_i), .resetn_i(resetn_i), .enable_i(enable_i),
		.smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o),
		.event_flags_o(event_flags_o), .spi_sclk_o(spi_sclk_o), .spi_csn_o(spi_csn_o),
		.spi_sdio_o(spi_sdio_o), .spi_sdio_oen_o(spi_sdio_oen_o), .spi_sdio_i(sdio));
	atwr_sensor_model atwr_sensor_model_i (.sclk_i(spi_sclk_o), .csn_i(spi_csn_o), .sdio_i(sdio),
		.sdio_o(m_sdio), .drive_o(m_drive));
	// Idle clock low, or both ends driving, or driving while deselected
	always @(posedge clk_i)
	begin
		if (resetn_i && spi_csn_o && (!spi_sclk_o || !spi_sdio_oen_o)) faults++;
		if (m_drive && !spi_sdio_oen_o) faults++;
	end
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task check(input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A bounded wait that ran out ends the run
	task need(input logic ok);
		if (!ok)
		begin
			errors++;
			report_and_stop();
		end
	endtask
	task test_config;
		for (int i = 0; i < 4000 && event_flags_o !== 8'h3f; i++) @(posedge clk_i);
		need(event_flags_o === 8'h3f);
		check(atwr_sensor_model_i.regs[6'h31], 8'h40);
		check(atwr_sensor_model_i.early_reads, 0);
		check(atwr_sensor_model_i.regs[6'h2c], 8'h0c);
		check(smp_valid_o, 1'b0);
		check(atwr_sensor_model_i.bursts, 0);
		$display("config and not-ready poll done");
	endtask
	task test_sample;
		atwr_sensor_model_i.regs[6'h30] = 8'hff;
		for (int i = 0; i < 4000 && smp_valid_o !== 1'b1; i++) @(posedge clk_i);
		need(smp_valid_o === 1'b1);
		check(smp_data_o, 48'h112233445566);
		check(event_flags_o, 8'hff);
		check(atwr_sensor_model_i.bursts, 1);
		$display("sample burst done");
	endtask
	task test_fill;
		for (int i = 0; i < 80000 && atwr_sensor_model_i.bursts < 32; i++) @(posedge clk_i);
		need(atwr_sensor_model_i.bursts >= 32);
		repeat (4000) @(posedge clk_i);
		check(atwr_sensor_model_i.bursts, 32);
		atwr_sensor_model_i.regs[6'h30] = 8'h00;
		smp_ready_i <= 1'b1;
		for (int i = 0; i < 4000 && smp_valid_o !== 1'b0; i++) @(posedge clk_i);
		check(smp_valid_o, 1'b0);
		check(faults, 0);
		$display("fill and drain done");
	endtask
	// Reset, start, then the scenarios in order
	initial
	begin
		{resetn_i, enable_i, smp_ready_i, errors, num_checks, faults} = '0;
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		enable_i <= 1'b1;
		atwr_sensor_model_i.regs[6'h30] = 8'h3f;
		test_config();
		test_sample();
		test_fill();
		report_and_stop();
	end
endmodule // tb_atwr_reader
`default_nettype wire
